//--- verilog/mbc_pkg.sv
// package: constants for the modem block checksum unit
package mbc_pkg;
  localparam int unsigned CLK_MHZ        = 200;
  localparam logic [14:0] POLY           = 15'h6815; // x^14,x^13,x^11,x^4,x^2,1
  localparam int unsigned BLOCK_BYTES    = 6;
  localparam int unsigned MSG_BITS       = 48;
  localparam int unsigned CODE_BITS      = 64;
  localparam logic [6:0]  CHK_LAST_DIV   = 7'd62;  // bit 63, zero based
  localparam logic [6:0]  CHK_PAR_BIT    = 7'd63;  // bit 64, zero based
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_MASK      = 12'h008;
  localparam logic [11:0] ADDR_TXDATA    = 12'h00c;
  localparam logic [11:0] ADDR_SYNDROME  = 12'h010;
  localparam int unsigned CTRL_INS_EN    = 0;
  localparam int unsigned CTRL_RX_EN     = 1;
  localparam int unsigned ST_TX_BYTE     = 0;
  localparam int unsigned ST_RX_PASS     = 1;
  localparam int unsigned ST_RX_DONE     = 2;
  localparam int unsigned ST_SYNC_HIT    = 3;
  localparam logic [3:0]  STATUS_RST     = 4'h0;
  localparam logic [3:0]  MASK_RST       = 4'h0;
  localparam logic [1:0]  CTRL_RST       = 2'h0;
  localparam logic [15:0] SYNC_WORD_A    = 16'hc4d7;
  localparam logic [15:0] SYNC_WORD_B    = 16'h3b28;
endpackage : mbc_pkg

//--- verilog/mbc_div_if.sv
// interface: one serial divider lane between top and divider
`timescale 1ns/100ps
interface mbc_div_if;
  logic        clear;
  logic        shift;
  logic        din;
  logic        inv;
  logic [14:0] rem;
  logic        par;
  modport ctl (output clear, output shift, output din, output inv, input rem, input par);
  modport div (input clear, input shift, input din, input inv, output rem, output par);
endinterface : mbc_div_if

//--- verilog/mbc_divider.sv
// serial modulo-2 polynomial divider with even parity accumulator
`timescale 1ns/100ps
module mbc_divider (
  input  wire logic clk_sys,
  input  wire logic nrst,
  mbc_div_if.div    d
);
  logic [14:0] rem_q;
  logic        par_q;
  logic        bit_in;
  logic        fb;
  assign bit_in = d.din ^ d.inv;
  assign fb     = bit_in ^ rem_q[14];
  assign d.rem  = rem_q;
  assign d.par  = par_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rem_q <= 15'h0000;
      par_q <= 1'b0;
    end else if (d.clear) begin
      rem_q <= 15'h0000;
      par_q <= 1'b0;
    end else if (d.shift) begin
      rem_q <= {rem_q[13:0], 1'b0} ^ (fb ? mbc_pkg::POLY : 15'h0000);
      par_q <= par_q ^ bit_in;
    end
  end
endmodule : mbc_divider

//--- verilog/mbc_top.sv
// top: checksum generator, checker and apb register file
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
// Overview of operation
// - tx divides 48 bits of six loaded bytes by the x^15 polynomial
// - tx remainder's final bit is inverted before forming the checksum
// - even parity over message and modified remainder completes 16-bit checksum
// - rx divides first 63 bits, bit 63 inverted, checks remainder zero
// - rx even parity over 63 bits compared with received bit 64
// - pass flag set only for zero remainder and matching parity
// - with insertion enabled, two checksum bytes follow every six back-to-back message bytes; an idle gap restarts the block
// - syndrome of 15 remainder bits plus parity-error bit is readable
// - transmit bytes serialised msb first into line and divider
// - sync word detection suppressed while checker processes a codeword
module mbc_top (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bit_tick,
  input  wire logic        rx_bit,
  output logic             tx_bit,
  output logic             tx_busy,
  output logic             sync_det,
  output logic             frame_sync_word_b,
  output logic             irq
);
  typedef enum logic [1:0] {MBC_IDLE, MBC_MSG, MBC_CHK} mbc_tx_e;
  mbc_div_if txd ();
  mbc_div_if rxd ();
  mbc_divider u_txdiv (.clk_sys(clk_sys), .nrst(nrst), .d(txd));
  mbc_divider u_rxdiv (.clk_sys(clk_sys), .nrst(nrst), .d(rxd));

  logic [1:0]  ctrl_q;
  logic [3:0]  stat_q, mask_q, stat_d;
  logic [15:0] synd_q;
  mbc_tx_e     tst_q;
  logic [7:0]  tbuf_q;
  logic        tbuf_full_q;
  logic [15:0] tsh_q;
  logic [3:0]  tbit_q;
  logic [2:0]  tbyte_q;
  logic [6:0]  rcnt_q;
  logic        rx_act_q;
  logic [15:0] rsh_q;
  logic        sync_a_q, sync_b_q;

  // apb decode
  logic acc, wr, rd_ok;
  assign acc   = psel & penable & pready;
  assign wr    = acc & pwrite;
  assign rd_ok = (paddr == mbc_pkg::ADDR_CTRL) || (paddr == mbc_pkg::ADDR_STATUS)
              || (paddr == mbc_pkg::ADDR_MASK) || (paddr == mbc_pkg::ADDR_TXDATA)
              || (paddr == mbc_pkg::ADDR_SYNDROME);
  logic wr_ctrl, wr_stat, wr_mask, wr_tx;
  assign wr_ctrl = wr & (paddr == mbc_pkg::ADDR_CTRL);
  assign wr_stat = wr & (paddr == mbc_pkg::ADDR_STATUS);
  assign wr_mask = wr & (paddr == mbc_pkg::ADDR_MASK);
  assign wr_tx   = wr & (paddr == mbc_pkg::ADDR_TXDATA);
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (paddr == mbc_pkg::ADDR_CTRL) begin
      rdata[1:0] = ctrl_q;
    end else if (paddr == mbc_pkg::ADDR_STATUS) begin
      rdata[3:0] = stat_q;
    end else if (paddr == mbc_pkg::ADDR_MASK) begin
      rdata[3:0] = mask_q;
    end else if (paddr == mbc_pkg::ADDR_TXDATA) begin
      rdata[8:0] = {tbuf_full_q, tbuf_q};
    end else if (paddr == mbc_pkg::ADDR_SYNDROME) begin
      rdata[15:0] = synd_q;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= rdata;
      pslverr <= psel & ~penable & ~rd_ok;
    end
  end

  // transmit side
  logic tx_step, load_byte, tx_chk_start, tx_blk_end;
  logic [14:0] tx_mod_rem, tx_rem_fin;
  logic        tx_fb;
  assign tx_step    = bit_tick & (tst_q != MBC_IDLE);
  // last message bit folded in here: the divider clears on that same edge
  assign tx_fb      = txd.din ^ txd.rem[14];
  assign tx_rem_fin = {txd.rem[13:0], 1'b0} ^ (tx_fb ? mbc_pkg::POLY : 15'h0000);
  assign tx_mod_rem = {tx_rem_fin[14:1], ~tx_rem_fin[0]};
  assign tx_blk_end = tx_step & (tbit_q == 4'd0) & (tst_q == MBC_MSG)
                    & (tbyte_q == 3'(mbc_pkg::BLOCK_BYTES - 1));
  assign tx_chk_start = tx_blk_end & ctrl_q[mbc_pkg::CTRL_INS_EN];
  assign load_byte  = bit_tick & tbuf_full_q & ((tst_q == MBC_IDLE)
                    | ((tbit_q == 4'd0) & ~tx_chk_start & (tst_q == MBC_MSG
                    | tst_q == MBC_CHK)));
  assign txd.clear = tx_blk_end | (tst_q == MBC_IDLE);
  assign txd.shift = tx_step & (tst_q == MBC_MSG);
  assign txd.din   = tsh_q[15];
  assign txd.inv   = 1'b0;
  // parity of modified remainder joined to message parity
  logic tx_par;
  assign tx_par = txd.par ^ txd.din ^ (^tx_mod_rem);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tst_q   <= MBC_IDLE;
      tsh_q   <= 16'h0000;
      tbit_q  <= 4'd0;
      tbyte_q <= 3'd0;
    end else if (load_byte) begin
      tst_q   <= MBC_MSG;
      tsh_q   <= {tbuf_q, 8'h00};
      tbit_q  <= 4'd7;
      tbyte_q <= (tst_q == MBC_MSG && tbyte_q != 3'(mbc_pkg::BLOCK_BYTES - 1))
               ? tbyte_q + 3'd1 : 3'd0;
    end else if (tx_chk_start) begin
      tst_q  <= MBC_CHK;
      tsh_q  <= {tx_mod_rem, tx_par};
      tbit_q <= 4'd15;
    end else if (tx_step) begin
      if (tbit_q == 4'd0) begin
        tst_q <= MBC_IDLE;
        if (tst_q == MBC_MSG && tbyte_q == 3'(mbc_pkg::BLOCK_BYTES - 1)) begin
          tbyte_q <= 3'd0;
        end
      end else begin
        tsh_q  <= {tsh_q[14:0], 1'b0};
        tbit_q <= tbit_q - 4'd1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tbuf_q      <= 8'h00;
      tbuf_full_q <= 1'b0;
      tx_bit      <= 1'b0;
      tx_busy     <= 1'b0;
    end else begin
      if (wr_tx) begin
        tbuf_q      <= pwdata[7:0];
        tbuf_full_q <= 1'b1;
      end else if (load_byte) begin
        tbuf_full_q <= 1'b0;
      end
      tx_bit  <= (tst_q == MBC_IDLE) ? 1'b0 : tsh_q[15];
      tx_busy <= (tst_q != MBC_IDLE);
    end
  end

  // receive side
  logic rx_en, rx_start, rx_last, rx_step;
  logic rx_pass, rx_par_err;
  logic sync_hit_a, sync_hit_b;
  assign rx_en    = ctrl_q[mbc_pkg::CTRL_RX_EN];
  assign rx_step  = bit_tick & rx_en;
  assign rx_start = rx_step & ~rx_act_q & (sync_hit_a | sync_hit_b);
  assign rx_last  = rx_step & rx_act_q & (rcnt_q == mbc_pkg::CHK_PAR_BIT);
  assign rxd.clear = rx_start | ~rx_en;
  assign rxd.shift = rx_step & rx_act_q & (rcnt_q != mbc_pkg::CHK_PAR_BIT);
  assign rxd.din   = rx_bit;
  assign rxd.inv   = (rcnt_q == mbc_pkg::CHK_LAST_DIV);
  // accumulator saw bit 63 inverted, so one more inversion restores its parity
  assign rx_par_err = rxd.par ^ 1'b1 ^ rx_bit;
  assign rx_pass    = (rxd.rem == 15'h0000) & ~rx_par_err;

  logic [15:0] rsh_d;
  assign rsh_d      = {rsh_q[14:0], rx_bit};
  assign sync_hit_a = ~rx_act_q & (rsh_d == mbc_pkg::SYNC_WORD_A);
  assign sync_hit_b = ~rx_act_q & (rsh_d == mbc_pkg::SYNC_WORD_B);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_act_q <= 1'b0;
      rcnt_q   <= 7'd0;
      rsh_q    <= 16'h0000;
      synd_q   <= 16'h0000;
      sync_a_q <= 1'b0;
      sync_b_q <= 1'b0;
    end else begin
      sync_a_q <= rx_step & sync_hit_a;
      sync_b_q <= rx_step & sync_hit_b;
      if (!rx_en) begin
        rx_act_q <= 1'b0;
        rcnt_q   <= 7'd0;
      end else if (rx_step) begin
        rsh_q <= rsh_d;
        if (rx_start) begin
          rx_act_q <= 1'b1;
          rcnt_q   <= 7'd0;
        end else if (rx_last) begin
          rx_act_q <= 1'b0;
          synd_q   <= {~rx_pass & ~(rxd.rem != 15'h0000) | rx_par_err, 
                       rxd.rem[0], rxd.rem[1], rxd.rem[2], rxd.rem[3], rxd.rem[4],
                       rxd.rem[5], rxd.rem[6], rxd.rem[7], rxd.rem[8], rxd.rem[9],
                       rxd.rem[10], rxd.rem[11], rxd.rem[12], rxd.rem[13],
                       rxd.rem[14]};
        end else if (rx_act_q) begin
          rcnt_q <= rcnt_q + 7'd1;
        end
      end
    end
  end

  // control, sticky status, mask, interrupt
  logic [3:0] ev;
  assign ev[mbc_pkg::ST_TX_BYTE]  = load_byte;
  assign ev[mbc_pkg::ST_RX_PASS]  = rx_last & rx_pass;
  assign ev[mbc_pkg::ST_RX_DONE]  = rx_last;
  assign ev[mbc_pkg::ST_SYNC_HIT] = rx_start;
  assign stat_d = (stat_q & ~(wr_stat ? pwdata[3:0] : 4'h0)) | ev;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q            <= mbc_pkg::CTRL_RST;
      stat_q            <= mbc_pkg::STATUS_RST;
      mask_q            <= mbc_pkg::MASK_RST;
      irq               <= 1'b0;
      sync_det          <= 1'b0;
      frame_sync_word_b <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      if (wr_mask) begin
        mask_q <= pwdata[3:0];
      end
      stat_q            <= stat_d;
      irq               <= |(stat_d & mask_q);
      sync_det          <= sync_a_q;
      frame_sync_word_b <= sync_b_q;
    end
  end
endmodule : mbc_top

//--- verification/mbc_top_asserts.sv
// checker: port-level assertions for the block checksum unit
`timescale 1ns/100ps
module mbc_top_asserts (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_tick,
  input wire logic tx_bit,
  input wire logic tx_busy,
  input wire logic sync_det,
  input wire logic frame_sync_word_b
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  setup_gets_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  ready_in_access_a: assert property (pready |-> psel && penable && $past(psel))
    else $error("ready outside access phase");
  slverr_with_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  idle_line_low_a: assert property (!tx_busy |-> !tx_bit)
    else $error("line not low while idle");
  sync_a_timing_a: assert property (sync_det |-> $past(bit_tick, 2))
    else $error("sync a pulse not two cycles after tick");
  sync_b_timing_a: assert property (frame_sync_word_b |-> $past(bit_tick, 2))
    else $error("sync b pulse not two cycles after tick");
  sync_single_pulse_a: assert property (sync_det |=> !sync_det)
    else $error("sync a pulse too long");
  sync_exclusive_a: assert property (!(sync_det && frame_sync_word_b))
    else $error("both sync words at once");
endmodule : mbc_top_asserts

//--- verification/mbc_modem_model.sv
// model: free-running modem bit clock and receive bit stream
`timescale 1ns/100ps
module mbc_modem_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        load,
  input  wire logic [79:0] frame,
  output logic             bit_tick,
  output logic             rx_bit,
  output logic             busy
);
  logic [1:0]  div_q;
  logic [79:0] sh_q;
  logic [6:0]  cnt_q;
  assign busy = (cnt_q != 7'h00);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_q    <= 2'h0;
      bit_tick <= 1'b0;
      rx_bit   <= 1'b0;
      cnt_q    <= 7'h00;
      sh_q     <= '0;
    end else begin
      div_q    <= div_q + 2'h1;
      bit_tick <= (div_q == 2'h3);
      if (load) begin
        sh_q  <= frame;
        cnt_q <= 7'd80;
      end else if (bit_tick) begin
        // outside frames an alternating pattern, never a sync word
        rx_bit <= busy ? sh_q[79] : ~rx_bit;
        if (busy) begin
          sh_q  <= {sh_q[78:0], 1'b0};
          cnt_q <= cnt_q - 7'h01;
        end
      end
    end
  end
endmodule : mbc_modem_model

//--- verification/tb_top.sv
// testbench: transmit checksum, receive check, registers and interrupt
`timescale 1ns/100ps
module tb_top;
  logic        clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, load = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, bit_tick, rx_bit, tx_bit, tx_busy, sync_det, sync_b, irq, er;
  logic [79:0] frame = '0;
  logic [63:0] cap = '0, cw, rnd, c3;
  int          sa_n = 0, sb_n = 0;
  logic [47:0] msg;
  logic        busy;
  int          fails = 0, tests_run = 0, cap_n = 0;
  always #2.5 clk_sys = ~clk_sys;
  mbc_top u_mbc_top (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_tick(bit_tick), .rx_bit(rx_bit), .tx_bit(tx_bit),
    .tx_busy(tx_busy), .sync_det(sync_det), .frame_sync_word_b(sync_b), .irq(irq));
  mbc_modem_model u_mbc_modem_model (.clk_sys(clk_sys), .nrst(nrst), .load(load),
    .frame(frame), .bit_tick(bit_tick), .rx_bit(rx_bit), .busy(busy));
  always @(posedge clk_sys) if (bit_tick === 1'b1 && tx_busy === 1'b1 && cap_n < 64) begin
    cap = {cap[62:0], tx_bit};
    cap_n++;
  end
  always @(posedge clk_sys) begin
    if (sync_det === 1'b1) sa_n++;
    if (sync_b === 1'b1) sb_n++;
  end
  function automatic logic [63:0] exp_cw(input logic [47:0] m);
    logic [14:0] r;
    logic        fb;
    r = '0;
    for (int i = 47; i >= 0; i--) begin
      fb = r[14] ^ m[i];
      r = {r[13:0], 1'b0} ^ (fb ? mbc_pkg::POLY : 15'h0000);
    end
    r[0] = ~r[0];
    return {m, r, ^{m, r}};
  endfunction : exp_cw
  function automatic logic [15:0] exp_syn(input logic [63:0] c);
    logic [14:0] r;
    logic [15:0] s;
    r = '0;
    for (int i = 63; i >= 1; i--) begin
      r = {r[13:0], 1'b0} ^ ((r[14] ^ c[i] ^ (i == 1)) ? mbc_pkg::POLY : 15'h0000);
    end
    s[15] = ^c;
    for (int i = 0; i < 15; i++) begin
      s[i] = r[14 - i];
    end
    return s;
  endfunction : exp_syn
  task automatic tx_bytes(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      do apb(0, mbc_pkg::ADDR_TXDATA, 0); while (rd[8] !== 1'b0);
      apb(1, mbc_pkg::ADDR_TXDATA, {24'h0, v[i*8 +: 8]});
    end
  endtask : tx_bytes
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rx_frame(input logic [15:0] sw, input logic [63:0] c);
    @(posedge clk_sys);
    frame <= {sw, c};
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
    @(posedge clk_sys);
    while (busy) @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
  endtask : rx_frame
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    #300000;
    fails++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h194456ed));
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    apb(0, mbc_pkg::ADDR_CTRL, 0);   chk(rd, 0);
    apb(0, mbc_pkg::ADDR_STATUS, 0); chk(rd, 0);
    apb(0, mbc_pkg::ADDR_MASK, 0);   chk(rd, 0);
    apb(0, 12'h7fc, 0);              chk({er, rd[30:0]}, 32'h80000000);
    rnd = {$urandom, $urandom};
    msg = rnd[47:0];
    apb(1, mbc_pkg::ADDR_CTRL, 32'h3);
    tx_bytes({16'h0000, msg}, 6);
    wait (cap_n == 64);
    cw = exp_cw(msg);
    chk(cap[63:32], cw[63:32]);
    chk(cap[31:16], cw[31:16]);
    chk(cap[15:2], cw[15:2]);
    chk(cap[1], cw[1]);
    chk(cap[0], cw[0]);
    apb(1, mbc_pkg::ADDR_STATUS, 32'hf);
    apb(1, mbc_pkg::ADDR_MASK, 32'h1 << mbc_pkg::ST_RX_DONE);
    rx_frame(mbc_pkg::SYNC_WORD_A, cw);
    apb(0, mbc_pkg::ADDR_STATUS, 0); chk(rd[2:1], 2'b11);
    apb(0, mbc_pkg::ADDR_SYNDROME, 0); chk(rd[15:0], 0);
    chk(irq, 1);
    apb(1, mbc_pkg::ADDR_STATUS, 32'hf);
    @(posedge clk_sys);
    chk(irq, 0);
    rx_frame(mbc_pkg::SYNC_WORD_B, cw ^ 64'h1);
    apb(0, mbc_pkg::ADDR_STATUS, 0); chk(rd[2:1], 2'b10);
    apb(0, mbc_pkg::ADDR_SYNDROME, 0); chk(rd[15:0], 32'h8000);
    apb(1, mbc_pkg::ADDR_STATUS, 32'hf);
    c3 = cw ^ (64'h1 << ($urandom % 48 + 16));
    rx_frame(mbc_pkg::SYNC_WORD_A, c3);
    apb(0, mbc_pkg::ADDR_STATUS, 0); chk(rd[2:1], 2'b10);
    apb(0, mbc_pkg::ADDR_SYNDROME, 0); chk(rd[15], 1);
    chk(rd[14:0] != 15'h0, 1);
    chk(rd[15:0], exp_syn(c3));
    apb(1, mbc_pkg::ADDR_STATUS, 32'hf);
    // clean codeword carrying a sync word inside it
    rnd = {$urandom, $urandom};
    msg = {mbc_pkg::SYNC_WORD_B, rnd[31:0]};
    rx_frame(mbc_pkg::SYNC_WORD_A, exp_cw(msg));
    apb(0, mbc_pkg::ADDR_STATUS, 0); chk(rd[2:1], 2'b11);
    chk(sa_n, 3);
    chk(sb_n, 1);
    cap_n = 0;
    apb(1, mbc_pkg::ADDR_CTRL, 32'h2);
    tx_bytes(rnd, 8);
    wait (cap_n == 64);
    chk(cap[63:32], rnd[63:32]);
    chk(cap[31:0], rnd[31:0]);
    complete_run();
  end
endmodule : tb_top
bind mbc_top mbc_top_asserts u_mbc_top_asserts (.clk_sys(clk_sys), .nrst(nrst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .bit_tick(bit_tick), .tx_bit(tx_bit), .tx_busy(tx_busy), .sync_det(sync_det),
  .frame_sync_word_b(frame_sync_word_b));
